//--- core/pst_sequencer.sv
// Push-button power-on/off sequencer core.
// Assumes button, hold and supply inputs are asynchronous pins; straps are static.
//
// What this block does
// - Long press: both buttons past settle+pulse+extra
// - Reset option: pulse reset low for reset time
// - Power-off option: drop supply enable instead
// - Second button armed by its falling edge
// - Enable low means low-power standby
// - Standby watches only main button falling edge
// - Reference output off during standby
// - Weak pull-down on hold request during startup
// - Hold-confirm: early hold keeps power after release
// - Hold-confirm: held at window end samples hold
// - Hold-confirm: release without hold drops enable
// - Fixed window: ignore hold until window end
// - Fixed window: low hold at end drops enable
// - Hold-confirm sees both edges; fixed only falling
// - Interrupt output stays high during power-up
// - After long-press reset: fixed-window hold check
// - Power-off option forces enable low after extra
// - Supply recovering before delay keeps power
// - Supply still low after delay drops enable
// - After undervoltage off, wait for normal startup
// - Button state ignores lows shorter than settle
// - Button state low pulses last minimum pulse
// - Hold request low in operation drops enable
// - Button state separates button from undervoltage
`timescale 1ns/1ps
`include "pst_map.svh"
module pst_sequencer #(
	parameter int SETTLE_TICKS  = `PST_SETTLE_US,  // Button settle time
	parameter int INT_MIN_TICKS = `PST_INT_MIN_US, // Minimum interrupt pulse
	parameter int RESET_TICKS   = `PST_RESET_US,   // reset_pulse_time
	parameter int WINDOW_TICKS  = `PST_WINDOW_US,  // Startup window
	parameter int EXTRA_TICKS   = `PST_EXTRA_US    // long_press_extra
) (
	input  wire logic clock,              // 100 MHz system clock
	input  wire logic rst,                // Asynchronous reset, active high
	input  wire logic power_button_n,     // Main button pin, low when pressed
	input  wire logic second_button_n,    // Second button pin, low when pressed
	input  wire logic hold_request,       // Processor hold request pin
	input  wire logic supply_low,         // Supply below rise_threshold
	input  wire logic opt_hold_confirm,   // Strap: 1 hold-until-confirm, 0 fixed window
	input  wire logic opt_long_power_off, // Strap: 1 long press cuts power, 0 resets
	output logic      supply_en,          // Supply enable, active high
	output logic      reset_out_n,        // Processor reset, active low
	output logic      int_out_n,          // Interrupt, active low
	output logic      button_state_out_n, // Debounced button state, active low
	output logic      low_supply_flag_n,  // Undervoltage flag, active low
	output logic      vref_en,            // Reference output enable
	output logic      hold_pull_dn_en     // Weak pull-down on hold request
);
	import pst_pkg::*;

	localparam pst_cnt_t SETTLE_LIM = pst_cnt_t'(SETTLE_TICKS);
	localparam pst_cnt_t INTMIN_LIM = pst_cnt_t'(INT_MIN_TICKS);
	localparam pst_cnt_t RESET_LIM  = pst_cnt_t'(RESET_TICKS);
	localparam pst_cnt_t WINDOW_LIM = pst_cnt_t'(WINDOW_TICKS);
	localparam pst_cnt_t LONG_LIM   = pst_cnt_t'(SETTLE_TICKS + INT_MIN_TICKS + EXTRA_TICKS);
	localparam logic [`PST_TICK_W-1:0] TICK_LAST = `PST_TICK_W'(`PST_TICK_CYC - 1);

	// Two-flop synchronisers, one per button, hold and supply pin
	logic [3:0] pin_raw;
	logic [3:0] sync1_ff;
	logic [3:0] sync2_ff;
	assign pin_raw = {supply_low, hold_request, ~second_button_n, ~power_button_n};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			always_ff @(posedge clock or posedge rst)
			begin
				if (rst)
				begin
					sync1_ff[gi] <= 1'b0;
					sync2_ff[gi] <= 1'b0;
				end
				else
				begin
					sync1_ff[gi] <= pin_raw[gi];
					sync2_ff[gi] <= sync1_ff[gi];
				end
			end
		end
	endgenerate

	logic main_low;
	logic sec_low;
	logic hold;
	logic uv;
	assign main_low = sync2_ff[0];
	assign sec_low  = sync2_ff[1];
	assign hold     = sync2_ff[2];
	assign uv       = sync2_ff[3];

	// Registered state
	pst_state_t                state_ff;
	pst_state_t                nxt_state;
	logic [`PST_TICK_W-1:0]    tick_cnt_ff;
	logic [`PST_TICK_W-1:0]    nxt_tick_cnt;
	logic                      main_prev_ff;
	logic                      sec_prev_ff;
	logic                      after_lp_ff;
	logic                      nxt_after_lp;
	logic                      confirm_ff;
	logic                      nxt_confirm;
	logic                      sec_arm_ff;
	logic                      nxt_sec_arm;
	logic                      bso_low_ff;
	logic                      nxt_bso_low;
	logic                      opt_valid_ff;
	logic                      opt_hold_ff;
	logic                      opt_off_ff;

	logic tick;
	logic main_fall;
	logic main_rise;
	logic sec_fall;
	logic st_debounce;
	logic st_startup;
	logic st_run;
	logic hold_cfg;
	logic dbn_done;
	logic win_done;
	logic rst_done;
	logic int_done;
	logic lp_done;
	logic uv_done;

	assign tick        = (tick_cnt_ff == TICK_LAST);
	assign main_fall   = main_low && !main_prev_ff;
	assign main_rise   = !main_low && main_prev_ff;
	assign sec_fall    = sec_low && !sec_prev_ff;
	assign st_debounce = (state_ff == PST_DEBOUNCE);
	assign st_startup  = (state_ff == PST_STARTUP);
	assign st_run      = (state_ff == PST_RUN);
	// The long-press restart always uses the fixed-window check
	assign hold_cfg    = opt_hold_ff && !after_lp_ff;

	// Interval timers on the shared 1 us timebase
	pst_timer u_dbn (.clock(clock), .rst(rst), .tick(tick), .limit(SETTLE_LIM), .done(dbn_done),
		.run(main_low && (st_debounce ? !uv : st_run)));
	pst_timer u_win (.clock(clock), .rst(rst), .tick(tick), .run(st_startup), .limit(WINDOW_LIM),
		.done(win_done));
	pst_timer u_rst (.clock(clock), .rst(rst), .tick(tick), .run(st_startup), .limit(RESET_LIM),
		.done(rst_done));
	pst_timer u_int (.clock(clock), .rst(rst), .tick(tick), .run(bso_low_ff), .limit(INTMIN_LIM),
		.done(int_done));
	pst_timer u_lp (.clock(clock), .rst(rst), .tick(tick), .limit(LONG_LIM), .done(lp_done),
		.run(st_run && main_low && sec_low && sec_arm_ff));
	pst_timer u_uv (.clock(clock), .rst(rst), .tick(tick), .run(st_run && uv), .limit(LONG_LIM),
		.done(uv_done));

	// Timebase divider, edge history and strap capture after reset release
	always_comb
	begin
		nxt_tick_cnt = tick ? '0 : tick_cnt_ff + `PST_TICK_W'(1);
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			tick_cnt_ff  <= '0;
			main_prev_ff <= 1'b0;
			sec_prev_ff  <= 1'b0;
			opt_valid_ff <= 1'b0;
			opt_hold_ff  <= 1'b0;
			opt_off_ff   <= 1'b0;
		end
		else
		begin
			tick_cnt_ff  <= nxt_tick_cnt;
			main_prev_ff <= main_low;
			sec_prev_ff  <= sec_low;
			opt_valid_ff <= 1'b1;
			if (!opt_valid_ff)
			begin
				opt_hold_ff <= opt_hold_confirm;
				opt_off_ff  <= opt_long_power_off;
			end
		end
	end

	// Sequencer next state
	always_comb
	begin
		nxt_state    = state_ff;
		nxt_after_lp = after_lp_ff;
		nxt_confirm  = confirm_ff;
		case (state_ff)
			PST_STANDBY:
			begin
				// Only a fresh press of the main button wakes the block
				if (opt_valid_ff && main_fall)
					nxt_state = PST_DEBOUNCE;
			end
			PST_DEBOUNCE:
			begin
				if (!main_low)
					nxt_state = PST_STANDBY;
				else if (dbn_done)
				begin
					nxt_state    = PST_STARTUP;
					nxt_after_lp = 1'b0;
					nxt_confirm  = 1'b0;
				end
			end
			PST_STARTUP:
			begin
				if (hold_cfg && main_low && hold)
					nxt_confirm = 1'b1;
				// Release decides only for hold-confirm; fixed window waits
				if (hold_cfg && main_rise && !win_done)
					nxt_state = (confirm_ff || hold) ? PST_RUN : PST_STANDBY;
				else if (win_done)
					nxt_state = hold ? PST_RUN : PST_STANDBY;
			end
			PST_RUN:
			begin
				if (!hold)
					nxt_state = PST_STANDBY;
				else if (lp_done)
				begin
					nxt_state    = opt_off_ff ? PST_STANDBY : PST_STARTUP;
					nxt_after_lp = 1'b1;
					nxt_confirm  = 1'b0;
				end
				else if (uv_done)
					nxt_state = PST_STANDBY;
			end
			default:
				nxt_state = PST_STANDBY;
		endcase
	end

	// Second button arming and debounced button state
	always_comb
	begin
		// A new falling edge wins over the release that disarms
		nxt_sec_arm  = (st_run && sec_fall) ? 1'b1 : (sec_low && st_run && sec_arm_ff);
		nxt_bso_low  = bso_low_ff;
		if (!bso_low_ff && st_run && dbn_done)
			nxt_bso_low = 1'b1;
		else if (bso_low_ff && !main_low && int_done)
			nxt_bso_low = 1'b0;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_ff    <= PST_STANDBY;
			after_lp_ff <= 1'b0;
			confirm_ff  <= 1'b0;
			sec_arm_ff  <= 1'b0;
			bso_low_ff  <= 1'b0;
		end
		else
		begin
			state_ff    <= nxt_state;
			after_lp_ff <= nxt_after_lp;
			confirm_ff  <= nxt_confirm;
			sec_arm_ff  <= nxt_sec_arm;
			bso_low_ff  <= nxt_bso_low;
		end
	end

	// Outputs decode the state register, timer done and flag signals combinationally
	assign supply_en          = st_startup || st_run;
	assign vref_en            = supply_en;
	assign reset_out_n        = !(st_startup && !rst_done);
	assign hold_pull_dn_en    = st_startup || st_debounce;
	assign int_out_n          = !(st_run && (bso_low_ff || uv));
	assign button_state_out_n = !bso_low_ff;
	assign low_supply_flag_n  = !(st_run && uv);

	a_standby_quiet : assert property (@(posedge clock) disable iff (rst)
		(state_ff == PST_STANDBY) |-> !vref_en && !supply_en && reset_out_n)
		else $error("Reference or enable active in standby");

	a_startup_int_high : assert property (@(posedge clock) disable iff (rst)
		(st_startup || st_debounce) |-> int_out_n && hold_pull_dn_en)
		else $error("Interrupt low or pull-down off during power-up");

	a_reset_pulse : assert property (@(posedge clock) disable iff (rst)
		(st_run && hold && lp_done && !opt_off_ff) |=> !reset_out_n && supply_en)
		else $error("Long press did not pulse reset");

	a_long_power_off : assert property (@(posedge clock) disable iff (rst)
		(st_run && hold && lp_done && opt_off_ff) |=> !supply_en && reset_out_n)
		else $error("Long press did not cut power");

	a_hold_drop : assert property (@(posedge clock) disable iff (rst)
		(st_run && !hold) |=> !supply_en ##1 !supply_en)
		else $error("Hold request low did not drop enable");

	a_fixed_release : assert property (@(posedge clock) disable iff (rst)
		(st_startup && !hold_cfg && main_rise && !win_done) |=> st_startup)
		else $error("Fixed window reacted to button release");

	a_confirm_release : assert property (@(posedge clock) disable iff (rst)
		(st_startup && hold_cfg && main_rise && !win_done && !confirm_ff && !hold) |=> !supply_en)
		else $error("Release without hold kept power");

	a_uv_off : assert property (@(posedge clock) disable iff (rst)
		(st_run && hold && !lp_done && uv_done) |=> (state_ff == PST_STANDBY))
		else $error("Lasting undervoltage kept power");

	a_bso_min : assert property (@(posedge clock) disable iff (rst)
		$rose(button_state_out_n) |-> $past(int_done))
		else $error("Button state low pulse shorter than minimum");

	a_bso_settle : assert property (@(posedge clock) disable iff (rst)
		$fell(button_state_out_n) |-> $past(dbn_done) && $past(st_run))
		else $error("Button state fell before settle time");

endmodule : pst_sequencer

//--- common/pst_map.svh
// Timing constants for the push-button power sequencer.
// Assumes a 100 MHz system clock and a 1 us internal timebase tick.
`ifndef PST_MAP_SVH
`define PST_MAP_SVH

// Clock and timebase
`define PST_CLK_PERIOD_NS 10
`define PST_TICK_NS       1000
`define PST_TICK_CYC      (`PST_TICK_NS / `PST_CLK_PERIOD_NS)
`define PST_TICK_W        7

// Default interval lengths, in timebase ticks (1 us each)
`define PST_SETTLE_US     30000
`define PST_INT_MIN_US    15000
`define PST_RESET_US      200000
`define PST_WINDOW_US     2000000
`define PST_EXTRA_US      1000000

`endif

//--- common/pst_pkg.sv
// Types shared by the power sequencer and its interval timer.
// Assumes nothing beyond a SystemVerilog compiler.
package pst_pkg;

	// Interval count, wide enough for several seconds of 1 us ticks
	typedef logic [23:0] pst_cnt_t;

	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		PST_STANDBY  = 5'h01,
		PST_DEBOUNCE = 5'h02,
		PST_STARTUP  = 5'h04,
		PST_RUN      = 5'h08,
		PST_SPARE    = 5'h10
	} pst_state_t;

endpackage : pst_pkg

//--- core/pst_timer.sv
// Interval timer counting timebase ticks while its qualifier is high.
// Assumes tick is a one-cycle enable from the clock domain of clock.
`timescale 1ns/1ps
module pst_timer (
	input  wire logic          clock, // System clock
	input  wire logic          rst,   // Asynchronous reset, active high
	input  wire logic          tick,  // Timebase enable pulse
	input  wire logic          run,   // Qualifier; low restarts the interval
	input  wire pst_pkg::pst_cnt_t limit, // Interval length in ticks
	output logic               done   // High while run and interval elapsed
);
	import pst_pkg::*;

	pst_cnt_t cnt_ff;
	pst_cnt_t nxt_cnt;

	// Count up while qualified, saturate at the limit, clear when dropped
	always_comb
	begin
		nxt_cnt = cnt_ff;
		if (!run)
			nxt_cnt = '0;
		else if (tick && (cnt_ff < limit))
			nxt_cnt = cnt_ff + 24'h000001;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

	// Saturating compare keeps done a clean level until run falls
	assign done = run && (cnt_ff >= limit);

	a_timer_restart : assert property (@(posedge clock) disable iff (rst)
		!run |=> (cnt_ff == '0) && !done)
		else $error("Interval timer did not restart when its qualifier dropped");

endmodule : pst_timer

//--- tb/pst_host_model.sv
// Host processor model that drives the hold request pin once it has booted.
// Assumes the sequencer's supply, reset and pull-down enable outputs as inputs.
`timescale 1ns/1ps
module pst_host_model #(
	parameter int BOOT_CYC = 200 // Boot time after reset release
) (
	input  wire logic clock,        // System clock
	input  wire logic supply_en,    // Processor power
	input  wire logic reset_out_n,  // Processor reset, active low
	input  wire logic pull_dn_en,   // Sequencer weak pull-down
	input  wire logic keep,         // Processor confirms power
	input  wire logic quit,         // Processor asks for power-off
	output logic      hold_request  // Resolved hold pin level
);
	int   boot_cnt = 0;
	logic spin     = 1'b0;

	// Boot runs only while powered and out of reset
	always @(posedge clock)
	begin
		spin <= ~spin;
		if (!supply_en || !reset_out_n)
			boot_cnt <= 0;
		else if (boot_cnt < BOOT_CYC)
			boot_cnt <= boot_cnt + 1;
	end

	// An undriven pin with no pull toggles, so no stale level is ever read
	assign hold_request = (boot_cnt >= BOOT_CYC) ? (keep & ~quit)
		: (pull_dn_en ? 1'b0 : spin);
endmodule : pst_host_model

//--- tb/testbench.sv
// Self-checking bench for the push-button power sequencer.
// Assumes shortened interval parameters and the host model on the hold pin.
`timescale 1ns/1ps
module testbench;
	logic clock, rst, power_button_n, second_button_n, supply_low, opt_hold_confirm, opt_long_power_off;
	logic hold_request, supply_en, reset_out_n, int_out_n, button_state_out_n, low_supply_flag_n;
	logic vref_en, hold_pull_dn_en, keep, quit;
	int   n_mismatch  = 0;
	int   comparisons = 0;
	int   cycles      = 0;

	// Ticks of 100 cycles: settle 1000, pulse 500, reset 1000, window 3000, long 3000 cycles
	pst_sequencer #(.SETTLE_TICKS(10), .INT_MIN_TICKS(5), .RESET_TICKS(10), .WINDOW_TICKS(30),
		.EXTRA_TICKS(15)) i_pst_sequencer (.clock, .rst, .power_button_n, .second_button_n,
		.hold_request, .supply_low, .opt_hold_confirm, .opt_long_power_off, .supply_en, .reset_out_n,
		.int_out_n, .button_state_out_n, .low_supply_flag_n, .vref_en, .hold_pull_dn_en);
	pst_host_model i_pst_host_model (.clock, .supply_en, .reset_out_n, .pull_dn_en(hold_pull_dn_en),
		.keep, .quit, .hold_request);

	// 100 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Inputs always move 1 ns after the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait on supply_en (sel 0) or reset_out_n (sel 1)
	task automatic wait_for(input logic sel, input logic v, input int n);
		while (((sel ? reset_out_n : supply_en) !== v) && n > 0)
		begin
			cyc(1);
			n--;
		end
		chk(sel ? reset_out_n : supply_en, v);
	endtask : wait_for

	task automatic fin(input string s);
		$display("end of test %s, mismatches so far %0d", s, n_mismatch);
	endtask : fin

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	// Straps are captured only after reset release, so each variant needs a reset
	task automatic do_reset(input logic hc, input logic off);
		{opt_hold_confirm, opt_long_power_off, rst} = {hc, off, 1'b1};
		{keep, quit, supply_low} = 3'h0;
		{power_button_n, second_button_n} = 2'h3;
		cyc(4);
		rst = 1'b0;
		cyc(5);
	endtask : do_reset

	// Press and hold until power comes up; returns at startup entry
	task automatic power_up();
		power_button_n = 1'b0;
		wait_for(0, 1, 1300);
		chk({reset_out_n, hold_pull_dn_en, int_out_n, vref_en}, 4'h7);
	endtask : power_up

	// Confirmed startup on the hold-until-confirm variant, button released early
	task automatic run_up();
		keep = 1'b1;
		power_up();
		cyc(1500);
		power_button_n = 1'b1;
		cyc(50);
	endtask : run_up

	task automatic t_standby();
		chk({supply_en, vref_en, reset_out_n, int_out_n}, 4'h3);
		chk({button_state_out_n, low_supply_flag_n, hold_pull_dn_en}, 3'h6);
		{second_button_n, supply_low} = 2'h1;
		cyc(1500);
		chk(supply_en, 0);
		{second_button_n, supply_low} = 2'h2;
		fin("standby");
	endtask : t_standby

	task automatic t_hc_confirm();
		run_up();
		chk({supply_en, hold_pull_dn_en}, 2'h2);
		quit = 1'b1;
		wait_for(0, 0, 20);
		chk(vref_en, 0);
		quit = 1'b0;
		fin("hold confirm");
	endtask : t_hc_confirm

	task automatic t_hc_nohold();
		keep = 1'b0;
		power_up();
		cyc(500);
		power_button_n = 1'b1;
		wait_for(0, 0, 20);
		chk(vref_en, 0);
		fin("hold missing");
	endtask : t_hc_nohold

	// Second button first; release during the new window must be ignored
	task automatic t_long_reset();
		run_up();
		second_button_n = 1'b0;
		cyc(10);
		power_button_n = 1'b0;
		cyc(2700);
		chk(reset_out_n, 1);
		wait_for(1, 0, 500);
		{power_button_n, second_button_n} = 2'h3;
		cyc(800);
		chk({reset_out_n, supply_en, hold_pull_dn_en}, 3'h3);
		wait_for(1, 1, 400);
		cyc(2400);
		chk({supply_en, hold_pull_dn_en}, 2'h2);
		fin("long press reset");
	endtask : t_long_reset

	task automatic t_fixed_nohold();
		power_up();
		cyc(300);
		power_button_n = 1'b1;
		cyc(2400);
		chk(supply_en, 1);
		wait_for(0, 0, 500);
		fin("fixed window drop");
	endtask : t_fixed_nohold

	task automatic t_fixed_ok();
		keep = 1'b1;
		power_up();
		cyc(300);
		power_button_n = 1'b1;
		cyc(3000);
		chk({supply_en, hold_pull_dn_en}, 2'h2);
		fin("fixed window keep");
	endtask : t_fixed_ok

	// A short press must leave no trace; a real one gives a minimum-width pulse
	task automatic t_button();
		int lo;
		lo = 0;
		for (int i = 0; i < 1700; i++)
		begin
			power_button_n = (i >= 500);
			cyc(1);
			lo += (button_state_out_n !== 1'b1);
		end
		chk(lo, 0);
		power_button_n = 1'b0;
		cyc(1150);
		chk({button_state_out_n, int_out_n, low_supply_flag_n}, 3'h1);
		power_button_n = 1'b1;
		cyc(200);
		chk(button_state_out_n, 0);
		cyc(600);
		chk({button_state_out_n, int_out_n}, 2'h3);
		fin("button interrupt");
	endtask : t_button

	task automatic t_undervolt();
		supply_low = 1'b1;
		cyc(20);
		chk({int_out_n, low_supply_flag_n, button_state_out_n}, 3'h1);
		cyc(1000);
		supply_low = 1'b0;
		cyc(2500);
		chk({supply_en, int_out_n}, 2'h3);
		supply_low = 1'b1;
		cyc(2800);
		chk(supply_en, 1);
		wait_for(0, 0, 400);
		supply_low = 1'b0;
		cyc(50);
		power_up();
		fin("undervoltage");
	endtask : t_undervolt

	// Held through the whole window, then main button first on the long press
	task automatic t_long_off();
		keep = 1'b1;
		power_up();
		cyc(3300);
		chk(supply_en, 1);
		power_button_n = 1'b1;
		cyc(50);
		power_button_n = 1'b0;
		cyc(10);
		second_button_n = 1'b0;
		cyc(2700);
		chk({supply_en, reset_out_n}, 2'h3);
		wait_for(0, 0, 500);
		chk(reset_out_n, 1);
		{power_button_n, second_button_n} = 2'h3;
		fin("long press off");
	endtask : t_long_off

	// Cut a hang short well past the expected run length
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial
	begin
		do_reset(1'b1, 1'b0);
		t_standby();
		t_hc_confirm();
		t_hc_nohold();
		t_long_reset();
		do_reset(1'b0, 1'b0);
		t_fixed_nohold();
		t_fixed_ok();
		t_button();
		t_undervolt();
		do_reset(1'b1, 1'b1);
		t_long_off();
		give_verdict();
	end
endmodule : testbench
